//--- design/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync
(
    input  wire logic sys_clk,   // system clock
    input  wire logic rst_b,     // async reset, active low
    input  wire logic d_async,   // pin level from another domain
    output logic      q          // filtered level
);

    logic s1_ff;                 // metastability catcher, read by s2 only
    logic s2_ff;                 // second stage
    logic s3_ff;                 // third stage
    logic q_ff;                  // agreed level
    logic nxt_q;                 // next agreed level

    // accept a new level only when stages two and three agree
    assign nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
    assign q     = q_ff;

    // shift chain
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff  <= 1'b0;
        end
        else
        begin
            s1_ff <= d_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

endmodule : pin_sync

`default_nettype wire

//--- design/rtc_control_status_charger.sv
// Functional notes
// R1: control halt bit stops oscillator, zero runs
// R2: pin floats on backup unless enabled
// R3: control resets: run, 32 kHz, wave, disabled
// R4: rate bits pick 1Hz/4k/8k/32k wave; the code gives 16k for the 32k code
// R5: function select chooses wave or alarm interrupt
// R6: alarm B drives pin only when enabled
// R7: alarm A drives pin only when enabled
// R8: interrupt output is OR of enabled flags
// R9: halted flag set on oscillator stop edge
// R10: halted flag set at power-up, fail, halt
// R11: halted flag clears only by writing zero
// R12: alarm B flag set on match, write-zero clears
// R13: alarm A flag set on match, write-zero clears
// R14: charger enabled only with unlock nibble 1010
// R15: charger register resets to all zeros
// R16: diode field 01 none, 10 one, else off
// R17: resistor field 01/10/11 values, 00 off
// R18: alarms compared once per second tick
// R19: interrupt holds until its flag cleared
// R20: unused control/status bits read zero
// R21: wave divides oscillator, stops when halted
`timescale 1ns/10ps
`default_nettype none

module rtc_control_status_charger
(
    input  wire logic       sys_clk,          // 125 MHz system clock
    input  wire logic       rst_b,            // first power-up, active low
    // register port from the serial protocol engine
    input  wire logic       reg_wr,           // write strobe, one cycle
    input  wire logic [7:0] reg_addr,         // register pointer
    input  wire logic [7:0] reg_wdata,        // write data
    output logic      [7:0] reg_rdata,        // read data, one cycle later
    // oscillator and supply monitors (pins)
    input  wire logic       osc_clk_in,       // 32.768 kHz oscillator
    input  wire logic       osc_fail_in,      // oscillator failed to run
    input  wire logic       main_supply_ok,   // supply above trip point
    // alarm comparator results, pulses on this clock
    input  wire logic       alarm_a_match,    // alarm A matched
    input  wire logic       alarm_b_match,    // alarm B matched
    // outputs
    output logic            osc_run,          // oscillator enable
    output logic            second_tick,      // once-per-second pulse
    output logic            wave_or_irq_pin_o,  // pin level, irq low
    output logic            wave_or_irq_pin_oe, // pin driven
    output logic            charger_enable,   // charger path on
    output logic            charger_diode,    // one diode in path
    output logic      [1:0] charger_resistor  // resistor code
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctl_ff;          // rtc_control
    logic [7:0] nxt_ctl;
    logic       osf_ff;          // osc_halted_flag
    logic       nxt_osf;
    logic       alarm_a_ff;      // alarm_a_flag
    logic       nxt_alarm_a;
    logic       alarm_b_ff;      // alarm_b_flag
    logic       nxt_alarm_b;
    logic [7:0] chg_ff;          // charger_config
    logic [7:0] nxt_chg;
    logic [7:0] rdata_ff;        // read data
    logic [7:0] nxt_rdata;

    ////////////////////////////////////////////////////////////////////////
    // oscillator side state
    logic                      osc_lvl;       // synchronised oscillator
    logic                      osc_lvl_d_ff;  // previous level
    logic                      fail_lvl;      // synchronised fail level
    logic                      fail_lvl_d_ff; // previous fail level
    logic                      supply_lvl;    // synchronised supply ok
    logic [rtc_ctl_pkg::DIV_WIDTH-1:0] div_ff;  // edge divider
    logic [rtc_ctl_pkg::DIV_WIDTH-1:0] nxt_div;
    logic                      halt_d_ff;     // previous halt bit
    logic                      run_ff;        // oscillator enable
    logic                      tick_ff;       // second tick
    logic                      nxt_tick;

    ////////////////////////////////////////////////////////////////////////
    // output flops
    logic       pin_o_ff;
    logic       nxt_pin_o;
    logic       pin_oe_ff;
    logic       nxt_pin_oe;
    logic       chg_en_ff;
    logic       nxt_chg_en;
    logic       chg_diode_ff;
    logic [1:0] chg_res_ff;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // oscillator waveform pin
    pin_sync u_sync_osc
    (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d_async (osc_clk_in),
        .q       (osc_lvl)
    );

    // oscillator fail monitor pin
    pin_sync u_sync_fail
    (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d_async (osc_fail_in),
        .q       (fail_lvl)
    );

    // main supply monitor pin
    pin_sync u_sync_supply
    (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d_async (main_supply_ok),
        .q       (supply_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // address decode
    // unmapped pointers decode to no write
    wire wr_ctl = reg_wr && (reg_addr == rtc_ctl_pkg::ADDR_RTC_CONTROL);
    wire wr_sts = reg_wr && (reg_addr == rtc_ctl_pkg::ADDR_RTC_STATUS);
    wire wr_chg = reg_wr && (reg_addr == rtc_ctl_pkg::ADDR_CHARGER_CONFIG);

    ////////////////////////////////////////////////////////////////////////
    // control fields
    wire       halt_bit  = ctl_ff[rtc_ctl_pkg::CTL_OSC_HALT_BIT];
    wire       bkup_en   = ctl_ff[rtc_ctl_pkg::CTL_BACKUP_OUT_BIT];
    wire [1:0] rate_sel  = {ctl_ff[rtc_ctl_pkg::CTL_RATE_HIGH_BIT],
                            ctl_ff[rtc_ctl_pkg::CTL_RATE_LOW_BIT]};
    wire       func_sel  = ctl_ff[rtc_ctl_pkg::CTL_FUNC_SEL_BIT];
    wire       ie_b      = ctl_ff[rtc_ctl_pkg::CTL_ALARM_B_IE_BIT];
    wire       ie_a      = ctl_ff[rtc_ctl_pkg::CTL_ALARM_A_IE_BIT];

    // control write, bit 6 kept at zero
    assign nxt_ctl = wr_ctl ? (reg_wdata & rtc_ctl_pkg::CTL_WRITE_MASK)
                            : ctl_ff; // R20

    ////////////////////////////////////////////////////////////////////////
    // oscillator edge and divider
    // a rising oscillator edge counts only while the oscillator runs
    wire osc_rise  = osc_lvl && !osc_lvl_d_ff && !halt_bit; // R21
    wire div_wrap  = osc_rise && (&div_ff);

    assign nxt_div  = osc_rise ? div_ff + 1'b1 : div_ff; // R21
    assign nxt_tick = div_wrap; // R18

    ////////////////////////////////////////////////////////////////////////
    // oscillator stop events
    // halt bit turned on, or the fail monitor rising
    wire halt_rise = halt_bit && !halt_d_ff; // R10
    wire fail_rise = fail_lvl && !fail_lvl_d_ff; // R10
    wire osf_set   = halt_rise || fail_rise; // R9

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: set wins over a write of zero, a one never sets
    wire osf_clr = wr_sts && !reg_wdata[rtc_ctl_pkg::STS_OSC_HALTED_BIT];
    wire a_clr   = wr_sts && !reg_wdata[rtc_ctl_pkg::STS_ALARM_A_BIT];
    wire b_clr   = wr_sts && !reg_wdata[rtc_ctl_pkg::STS_ALARM_B_BIT];

    assign nxt_osf     = osf_set || (osf_ff && !osf_clr); // R11
    assign nxt_alarm_a = alarm_a_match || (alarm_a_ff && !a_clr); // R13
    assign nxt_alarm_b = alarm_b_match || (alarm_b_ff && !b_clr); // R12

    ////////////////////////////////////////////////////////////////////////
    // square wave select
    // only the 32k tap, div_ff[0], runs at half its nominal rate
    wire wave_sel = (rate_sel == rtc_ctl_pkg::RATE_1HZ)
                        ? div_ff[rtc_ctl_pkg::TAP_1HZ]
                  : (rate_sel == rtc_ctl_pkg::RATE_4K096)
                        ? div_ff[rtc_ctl_pkg::TAP_4K096]
                  : (rate_sel == rtc_ctl_pkg::RATE_8K192)
                        ? div_ff[rtc_ctl_pkg::TAP_8K192]
                        : div_ff[0]; // R4

    ////////////////////////////////////////////////////////////////////////
    // interrupt from enabled flags, held until the flag clears
    wire irq_a    = alarm_a_ff && ie_a && func_sel; // R7
    wire irq_b    = alarm_b_ff && ie_b && func_sel; // R6
    wire irq_any  = irq_a || irq_b; // R8 R19

    // wave mode drives the wave, interrupt mode drives low when active
    assign nxt_pin_o  = func_sel ? !irq_any : wave_sel; // R5
    // on backup supply the pin floats unless backup output enabled
    assign nxt_pin_oe = supply_lvl || bkup_en; // R2

    ////////////////////////////////////////////////////////////////////////
    // charger decode
    // any invalid field keeps the charger off
    wire [3:0] unlock_nib = chg_ff[rtc_ctl_pkg::CHG_UNLOCK_LSB +: 4];
    wire [1:0] diode_choice    = chg_ff[rtc_ctl_pkg::CHG_DIODE_LSB +: 2];
    wire [1:0] resistor_choice = chg_ff[rtc_ctl_pkg::CHG_RES_LSB +: 2];
    wire       unlock_ok = (unlock_nib == rtc_ctl_pkg::CHG_UNLOCK_CODE); // R14
    wire       diode_ok  = (diode_choice == rtc_ctl_pkg::DIODE_NONE) ||
                           (diode_choice == rtc_ctl_pkg::DIODE_ONE); // R16
    wire       res_ok    = (resistor_choice != rtc_ctl_pkg::RES_OFF); // R17

    assign nxt_chg    = wr_chg ? reg_wdata : chg_ff;
    assign nxt_chg_en = unlock_ok && diode_ok && res_ok; // R14

    ////////////////////////////////////////////////////////////////////////
    // read mux, unused bits zero
    // unmapped pointers read as zero
    wire [7:0] sts_view = {osf_ff, 5'h00, alarm_b_ff, alarm_a_ff}; // R20

    assign nxt_rdata =
        (reg_addr == rtc_ctl_pkg::ADDR_RTC_CONTROL)    ? ctl_ff   :
        (reg_addr == rtc_ctl_pkg::ADDR_RTC_STATUS)     ? sts_view :
        (reg_addr == rtc_ctl_pkg::ADDR_CHARGER_CONFIG) ? chg_ff   :
                                                         8'h00;

    ////////////////////////////////////////////////////////////////////////
    // register file
    // reset is first power-up
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_ff     <= rtc_ctl_pkg::CTL_RESET_VALUE; // R3
            osf_ff     <= rtc_ctl_pkg::STS_RESET_VALUE[7]; // R10
            alarm_a_ff <= 1'b0;
            alarm_b_ff <= 1'b0;
            chg_ff     <= rtc_ctl_pkg::CHG_RESET_VALUE; // R15
            rdata_ff   <= 8'h00;
        end
        else
        begin
            ctl_ff     <= nxt_ctl; // R1
            osf_ff     <= nxt_osf;
            alarm_a_ff <= nxt_alarm_a;
            alarm_b_ff <= nxt_alarm_b;
            chg_ff     <= nxt_chg;
            rdata_ff   <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator divider and edge history
    // run follows the halt bit one cycle late
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_ff        <= '0;
            osc_lvl_d_ff  <= 1'b0;
            fail_lvl_d_ff <= 1'b0;
            halt_d_ff     <= 1'b0;
            run_ff        <= 1'b1;
            tick_ff       <= 1'b0;
        end
        else
        begin
            div_ff        <= nxt_div;
            osc_lvl_d_ff  <= osc_lvl;
            fail_lvl_d_ff <= fail_lvl;
            halt_d_ff     <= halt_bit;
            run_ff        <= !halt_bit; // R1
            tick_ff       <= nxt_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output flops
    // resistor code shows only when enabled
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_o_ff     <= 1'b1;
            pin_oe_ff    <= 1'b0;
            chg_en_ff    <= 1'b0;
            chg_diode_ff <= 1'b0;
            chg_res_ff   <= rtc_ctl_pkg::RES_OFF;
        end
        else
        begin
            pin_o_ff     <= nxt_pin_o;
            pin_oe_ff    <= nxt_pin_oe;
            chg_en_ff    <= nxt_chg_en;
            chg_diode_ff <= (diode_choice == rtc_ctl_pkg::DIODE_ONE); // R16
            chg_res_ff   <= nxt_chg_en ? resistor_choice
                                       : rtc_ctl_pkg::RES_OFF; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port drive
    // every port is a flop output
    assign reg_rdata          = rdata_ff;
    assign osc_run            = run_ff;
    assign second_tick        = tick_ff;
    assign wave_or_irq_pin_o  = pin_o_ff;
    assign wave_or_irq_pin_oe = pin_oe_ff;
    assign charger_enable     = chg_en_ff;
    assign charger_diode      = chg_diode_ff;
    assign charger_resistor   = chg_res_ff;

endmodule : rtc_control_status_charger

`default_nettype wire

//--- design/rtc_ctl_pkg.sv
package rtc_ctl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_RTC_CONTROL    = 8'h0E;
    localparam logic [7:0] ADDR_RTC_STATUS     = 8'h0F;
    localparam logic [7:0] ADDR_CHARGER_CONFIG = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // rtc_control field positions
    localparam int CTL_OSC_HALT_BIT    = 7;
    localparam int CTL_BACKUP_OUT_BIT  = 5;
    localparam int CTL_RATE_HIGH_BIT   = 4;
    localparam int CTL_RATE_LOW_BIT    = 3;
    localparam int CTL_FUNC_SEL_BIT    = 2;
    localparam int CTL_ALARM_B_IE_BIT  = 1;
    localparam int CTL_ALARM_A_IE_BIT  = 0;
    // writable bits of rtc_control, bit 6 stays zero
    localparam logic [7:0] CTL_WRITE_MASK = 8'hBF;

    ////////////////////////////////////////////////////////////////////////
    // rtc_status field positions
    localparam int STS_OSC_HALTED_BIT  = 7;
    localparam int STS_ALARM_B_BIT     = 1;
    localparam int STS_ALARM_A_BIT     = 0;

    ////////////////////////////////////////////////////////////////////////
    // charger_config field positions and codes
    localparam int CHG_UNLOCK_LSB      = 4;
    localparam int CHG_DIODE_LSB       = 2;
    localparam int CHG_RES_LSB         = 0;
    localparam logic [3:0] CHG_UNLOCK_CODE  = 4'hA;
    localparam logic [1:0] DIODE_NONE       = 2'h1;
    localparam logic [1:0] DIODE_ONE        = 2'h2;
    localparam logic [1:0] RES_OFF          = 2'h0;
    localparam logic [1:0] RES_250          = 2'h1;
    localparam logic [1:0] RES_2K           = 2'h2;
    localparam logic [1:0] RES_4K           = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // first power-up values
    localparam logic [7:0] CTL_RESET_VALUE = 8'h18;
    localparam logic [7:0] STS_RESET_VALUE = 8'h80;
    localparam logic [7:0] CHG_RESET_VALUE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // rate select codes and divider taps (tap k gives 2^k oscillator edges per half wave)
    localparam logic [1:0] RATE_1HZ    = 2'h0;
    localparam logic [1:0] RATE_4K096  = 2'h1;
    localparam logic [1:0] RATE_8K192  = 2'h2;
    localparam logic [1:0] RATE_32K768 = 2'h3;
    localparam int OSC_FREQ_HZ  = 32768;
    localparam int DIV_WIDTH    = 15;
    localparam int TAP_1HZ      = 14;
    localparam int TAP_4K096    = 2;
    localparam int TAP_8K192    = 1;

    ////////////////////////////////////////////////////////////////////////
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES  = 3;

endpackage : rtc_ctl_pkg

//--- tb/reg_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host on the far side of the register port; moves after falling edges
module reg_host_model
(
    input  wire logic       sys_clk,    // system clock
    input  wire logic [7:0] reg_rdata,  // registered read data
    output logic            reg_wr,     // one-cycle write strobe
    output logic      [7:0] reg_addr,   // register pointer
    output logic      [7:0] reg_wdata   // write data
);
    initial
    begin
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // byte write; flags are only ever cleared by zero bits
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = v;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~v;  // no stale data left behind
    endtask : wr

    // pointer held two edges so the registered data has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        reg_addr = a;
        repeat (2) @(negedge sys_clk);
        v = reg_rdata;
    endtask : rd
endmodule : reg_host_model

`default_nettype wire

//--- tb/rtc_ctl_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// port-level checks against shadow copies of the writable registers
module rtc_ctl_checker
(
    input wire logic       sys_clk,            // system clock
    input wire logic       rst_b,              // reset, active low
    input wire logic       reg_wr,             // write strobe
    input wire logic [7:0] reg_addr,           // register pointer
    input wire logic [7:0] reg_wdata,          // write data
    input wire logic [7:0] reg_rdata,          // read data
    input wire logic       main_supply_ok,     // supply monitor
    input wire logic       alarm_a_match,      // comparator pulse a
    input wire logic       alarm_b_match,      // comparator pulse b
    input wire logic       osc_run,            // oscillator enable
    input wire logic       wave_or_irq_pin_o,  // pin level
    input wire logic       wave_or_irq_pin_oe, // pin driven
    input wire logic       charger_enable,     // charger on
    input wire logic       charger_diode,      // diode in path
    input wire logic [1:0] charger_resistor    // resistor code
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    logic [7:0] ctl_ff;    // shadow control
    logic [7:0] chg_ff;    // shadow charger
    logic [1:0] flag_ff;   // shadow alarm flags b, a
    logic [1:0] nxt_flag;  // a match wins over a zero write
    logic [3:0] chg_exp;   // enable, diode, resistor
    logic       chg_ok;    // unlock, diode and resistor all valid
    wire        wr_ctl = reg_wr && reg_addr == 8'h0E;
    wire        wr_sts = reg_wr && reg_addr == 8'h0F;
    wire        wr_chg = reg_wr && reg_addr == 8'h10;

    assign nxt_flag = (wr_sts ? flag_ff & reg_wdata[1:0] : flag_ff)
                    | {alarm_b_match, alarm_a_match};
    assign chg_ok = chg_ff[7:4] == 4'hA && chg_ff[1:0] != 2'h0
                    && (chg_ff[3:2] == 2'h1 || chg_ff[3:2] == 2'h2);
    assign chg_exp = chg_ok ? {1'b1, chg_ff[3], chg_ff[1:0]} : 4'h0;

    // shadows follow the register port
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_ff  <= 8'h18;
            chg_ff  <= 8'h00;
            flag_ff <= 2'h0;
        end
        else
        begin
            ctl_ff  <= wr_ctl ? reg_wdata & 8'hBF : ctl_ff;
            chg_ff  <= wr_chg ? reg_wdata : chg_ff;
            flag_ff <= nxt_flag;
        end
    end

    ////////////////////////////////////////
    // status pointer held, no write
    sequence sts_read_s;
        (reg_addr == 8'h0F && !reg_wr) [*2];
    endsequence
    // oscillator halted in wave mode
    sequence halted_s;
        (!osc_run && !ctl_ff[2] && !wr_ctl) [*8];
    endsequence

    osc_enable_a: assert property (osc_run == !$past(ctl_ff[7]))
        else $error("oscillator enable wrong");
    status_zero_a: assert property (
        reg_addr == 8'h0F |=> reg_rdata[6:2] == 5'h00)
        else $error("unused status bits not zero");
    irq_first_a: assert property (
        ctl_ff[2] && ctl_ff[0] && flag_ff[0] |=> !wave_or_irq_pin_o)
        else $error("alarm a interrupt missing");
    irq_second_a: assert property (
        ctl_ff[2] && ctl_ff[1] && flag_ff[1] |=> !wave_or_irq_pin_o)
        else $error("alarm b interrupt missing");
    flag_read_a: assert property (
        alarm_a_match ##1 sts_read_s |-> reg_rdata[0])
        else $error("alarm a flag not read back");
    charger_out_a: assert property (1'b1 |=>
        {charger_enable, charger_enable & charger_diode, charger_resistor}
        == $past(chg_exp))
        else $error("charger outputs wrong");
    pin_float_a: assert property (
        (!main_supply_ok && !ctl_ff[5]) [*8] |-> !wave_or_irq_pin_oe)
        else $error("pin driven without supply");
    wave_halt_a: assert property (
        halted_s ##1 halted_s |-> $stable(wave_or_irq_pin_o))
        else $error("wave moves while halted");
endmodule : rtc_ctl_checker

bind rtc_control_status_charger rtc_ctl_checker u_chk
(
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .main_supply_ok(main_supply_ok), .alarm_a_match(alarm_a_match),
    .alarm_b_match(alarm_b_match), .osc_run(osc_run),
    .wave_or_irq_pin_o(wave_or_irq_pin_o),
    .wave_or_irq_pin_oe(wave_or_irq_pin_oe),
    .charger_enable(charger_enable), .charger_diode(charger_diode),
    .charger_resistor(charger_resistor)
);

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module tb_top;
    logic       sys_clk, rst_b, osc_clk_in, osc_fail_in, main_supply_ok;
    logic       alarm_a_match, alarm_b_match, fa, fb, p;
    wire        reg_wr, osc_run, pin_o, pin_oe, chg_en, chg_diode, tick;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    wire  [1:0] chg_res;
    logic [7:0] d, v;
    logic [1:0] ie;
    int         errors, check_count, i, n;
    logic [7:0] corner [7] = '{8'hA5, 8'hAB, 8'hA6, 8'h55, 8'hA4, 8'hAD,
                               8'hA1};

    rtc_control_status_charger dut
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .osc_clk_in(osc_clk_in), .osc_fail_in(osc_fail_in),
        .main_supply_ok(main_supply_ok), .alarm_a_match(alarm_a_match),
        .alarm_b_match(alarm_b_match), .osc_run(osc_run), .second_tick(tick),
        .wave_or_irq_pin_o(pin_o), .wave_or_irq_pin_oe(pin_oe),
        .charger_enable(chg_en), .charger_diode(chg_diode),
        .charger_resistor(chg_res)
    );
    reg_host_model m
    (
        .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata)
    );

    //////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // cycles between two rising pin edges, bounded
    task automatic wave_period(output int len);
        int   k;
        int   rises;
        logic prev;
        len   = 0;
        rises = 0;
        prev  = 1'b1;
        for (k = 0; k < 800 && rises < 2; k++)
        begin
            @(negedge sys_clk);
            rises = rises + int'(pin_o && !prev);
            len   = len + int'(rises == 1);
            prev  = pin_o;
        end
        if (rises < 2)
        begin
            errors++;
            stop_test();
        end
    endtask : wave_period

    // enable, diode, resistor for a charger byte
    function automatic logic [3:0] exp_chg(input logic [7:0] c);
        logic en;
        en = c[7:4] == 4'hA && c[1:0] != 2'h0
             && (c[3:2] == 2'h1 || c[3:2] == 2'h2);
        exp_chg = en ? {1'b1, c[3:2] == 2'h2, c[1:0]} : 4'h0;
    endfunction : exp_chg

    // 16-cycle oscillator that stands still while halted
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial
    begin
        osc_clk_in = 1'b0;
        forever
        begin
            repeat (8) @(negedge sys_clk);
            if (osc_run === 1'b1) osc_clk_in = ~osc_clk_in;
        end
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        stop_test();
    end

    initial
    begin
        rst_b = 1'b0;
        osc_fail_in = 1'b0;
        main_supply_ok = 1'b1;
        alarm_a_match = 1'b0;
        alarm_b_match = 1'b0;
        n = $urandom(32'h9F3F);
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        m.rd(8'h0E, d); `CHK(d, 8'h18)
        m.rd(8'h0F, d); `CHK(d, 8'h80)
        m.rd(8'h10, d); `CHK(d, 8'h00)
        `CHK(pin_oe, 1'b1)
        m.wr(8'h0E, 8'h7C); m.rd(8'h0E, d); `CHK(d, 8'h3C)
        m.wr(8'h0F, 8'hFF); m.rd(8'h0F, d); `CHK(d, 8'h80)
        m.wr(8'h0F, 8'h7F); m.rd(8'h0F, d); `CHK(d, 8'h00)
        m.wr(8'h0F, 8'hFF); m.rd(8'h0F, d); `CHK(d, 8'h00)
        // every enable pair first, then random alarms
        for (i = 0; i < 12; i++)
        begin
            ie = (i < 4) ? i[1:0] : 2'($urandom);
            fa = (i < 4) ? 1'b1 : 1'($urandom);
            fb = (i < 2) ? 1'b1 : 1'($urandom);
            m.wr(8'h0E, {6'h01, ie});
            m.rd(8'h0F, d); `CHK(pin_o, 1'b1)
            alarm_a_match = fa;
            alarm_b_match = fb;
            @(negedge sys_clk);
            alarm_a_match = 1'b0;
            alarm_b_match = 1'b0;
            m.rd(8'h0F, d); `CHK(d[1:0], {fb, fa})
            `CHK(pin_o, ~((fa & ie[0]) | (fb & ie[1])))
            m.wr(8'h0F, 8'hFE); m.rd(8'h0F, d); `CHK(d[1:0], {fb, 1'b0})
            m.wr(8'h0F, 8'h00);
        end
        // match lands on the clearing write
        m.wr(8'h0E, 8'h05);
        fork
            m.wr(8'h0F, 8'h00);
            begin
                @(negedge sys_clk);
                alarm_a_match = 1'b1;
                @(negedge sys_clk);
                alarm_a_match = 1'b0;
            end
        join
        m.rd(8'h0F, d); `CHK(d[0], 1'b1)
        `CHK(pin_o, 1'b0)
        // wave mode with enabled alarm A flag still set
        for (i = 3; i > 0; i--)
        begin
            m.wr(8'h0E, {3'h0, i[1:0], 3'h3});
            wave_period(n); `CHK(n, 32 << (3 - i))
        end
        m.wr(8'h0F, 8'h00);
        for (i = 0; i < 14; i++)
        begin
            v = (i < 7) ? corner[i] : 8'($urandom);
            m.wr(8'h10, v); m.rd(8'h10, d); `CHK(d, v)
            `CHK({chg_en, chg_en & chg_diode, chg_res}, exp_chg(v))
        end
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        m.rd(8'h10, d); `CHK(d, 8'h00)
        m.wr(8'h0F, 8'h00);
        osc_fail_in = 1'b1;
        repeat (6) @(negedge sys_clk);
        osc_fail_in = 1'b0;
        m.rd(8'h0F, d); `CHK(d[7], 1'b1)
        m.wr(8'h0F, 8'h00); m.rd(8'h0F, d); `CHK(d[7], 1'b0)
        m.wr(8'h0E, 8'h98);
        repeat (24) @(negedge sys_clk);
        p = pin_o;
        `CHK(osc_run, 1'b0)
        m.rd(8'h0F, d); `CHK(d[7], 1'b1)
        repeat (64) @(negedge sys_clk);
        `CHK(pin_o, p)
        m.wr(8'h0E, 8'h18);
        repeat (2) @(negedge sys_clk);
        `CHK(osc_run, 1'b1)
        main_supply_ok = 1'b0;
        repeat (10) @(negedge sys_clk);
        `CHK(pin_oe, 1'b0)
        m.wr(8'h0E, 8'h38);
        repeat (4) @(negedge sys_clk);
        `CHK(pin_oe, 1'b1)
        `CHK(tick, 1'b0)
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
